// File: design/ascp_defines.svh
// timing counts and code constants of the serial conversion port
`ifndef ASCP_DEFINES_SVH
`define ASCP_DEFINES_SVH
`define ASCP_RES_BITS 13
`define ASCP_CFG_BITS 5
`define ASCP_CODE_MIN 13'h1000
`define ASCP_CODE_MAX 13'h0FFF
`define ASCP_SAMPLE_HALF_EDGES 3
`endif

// File: design/ascp_pkg.sv
// types of the serial conversion port
package ascp_pkg;
	typedef enum logic [3:0] {
		ASCP_IDLE = 4'h1,
		ASCP_CFG = 4'h2,
		ASCP_SAMPLE = 4'h4,
		ASCP_CONV = 4'h8
	} ascp_state_t;
endpackage : ascp_pkg

// File: design/ascp_sync.sv
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/10ps
`default_nettype none
module ascp_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// pin and clean level
	input wire logic i_pin,
	output logic o_level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			o_level <= RST_VAL;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				o_level <= s3_q;
			end
		end
	end
endmodule : ascp_sync
`default_nettype wire

// File: design/ascp_port.sv
// serial control and result shifting of a 13-bit differential converter
// How it works
// R1 - select low starts a transaction
// R2 - select high aborts, enters standby
// R3 - host raises select between conversions
// R4 - configuration captured on serial clock rise
// R5 - output changes only on clock fall
// R6 - serial clock alone paces everything
// R7 - sampling lasts 1.5 serial clocks
// R8 - thirteen clocks resolve thirteen bits
// R9 - thirteen-bit two's complement bipolar codes
// R10 - out-of-range input saturates at extremes
// R11 - host selects pseudo-differential for bipolar
// R12 - result leaves sign bit first
// R13 - host keeps clock above minimum
// R14 - configuration layout is a parameter
`include "ascp_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ascp_port #(
	parameter int CFG_BITS = `ASCP_CFG_BITS,
	parameter int RES_BITS = `ASCP_RES_BITS,
	parameter int SGL_POS = CFG_BITS - 1
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// serial pins
	input wire logic i_select_shutdown_n,
	input wire logic i_sclk,
	input wire logic i_sdi,
	output logic o_sdo,
	output logic o_sdo_oe,
	// analog front end: signed difference sample, wider than the code
	input wire logic signed [RES_BITS+1:0] i_analog_diff,
	// status
	output logic [CFG_BITS-1:0] o_cfg,
	output logic o_standby,
	output logic o_sampling
);
	import ascp_pkg::*;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sclk_prev_q;
	ascp_state_t state_q;
	logic [CFG_BITS-1:0] cfg_q;
	logic [$clog2(CFG_BITS+1)-1:0] cfg_cnt_q;
	logic [1:0] half_q;
	logic [4:0] bit_cnt_q;
	logic [RES_BITS-1:0] res_q;
	logic rise;
	logic fall;
	////////////////////////////////////////////////////////////////////////
	ascp_sync #(.RST_VAL(1'b1)) u_cs (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_pin(i_select_shutdown_n), .o_level(cs_n));
	ascp_sync #(.RST_VAL(1'b0)) u_ck (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_pin(i_sclk), .o_level(sclk));
	ascp_sync #(.RST_VAL(1'b0)) u_di (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_pin(i_sdi), .o_level(sdi));
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk;
		end
	end
	// edges of the host clock are the only timing source
	assign rise = sclk & ~sclk_prev_q; // [R6]
	assign fall = ~sclk & sclk_prev_q; // [R6]
	////////////////////////////////////////////////////////////////////////
	// saturating quantiser of the held analog sample
	function automatic logic [RES_BITS-1:0] quantise(input logic signed [RES_BITS+1:0] v);
		logic signed [RES_BITS+1:0] lo;
		logic signed [RES_BITS+1:0] hi;
		lo = -(RES_BITS+2)'(1 << (RES_BITS-1));
		hi = (RES_BITS+2)'((1 << (RES_BITS-1)) - 1);
		if (v < lo) begin
			quantise = `ASCP_CODE_MIN; // [R10] [R9]
		end else if (v > hi) begin
			quantise = `ASCP_CODE_MAX; // [R10] [R9]
		end else begin
			quantise = v[RES_BITS-1:0]; // [R9]
		end
	endfunction : quantise
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_q <= ASCP_IDLE;
			cfg_cnt_q <= '0;
			half_q <= 2'h0;
			bit_cnt_q <= 5'h00;
		end else if (cs_n) begin
			state_q <= ASCP_IDLE; // [R2]
			cfg_cnt_q <= '0;
			half_q <= 2'h0;
			bit_cnt_q <= 5'h00;
		end else begin
			case (state_q)
				ASCP_IDLE: begin
					state_q <= ASCP_CFG; // [R1]
				end
				ASCP_CFG: begin
					if (rise) begin
						cfg_cnt_q <= cfg_cnt_q + 1'b1;
						if (cfg_cnt_q == ($clog2(CFG_BITS+1))'(CFG_BITS - 1)) begin
							state_q <= ASCP_SAMPLE;
						end
					end
				end
				ASCP_SAMPLE: begin
					// acquisition spans three host clock half periods
					if (rise | fall) begin
						half_q <= half_q + 2'h1; // [R7]
						if (half_q == 2'(`ASCP_SAMPLE_HALF_EDGES - 1)) begin
							state_q <= ASCP_CONV;
						end
					end
				end
				ASCP_CONV: begin
					if (fall && bit_cnt_q != 5'(RES_BITS)) begin
						bit_cnt_q <= bit_cnt_q + 5'h01; // [R8]
					end
				end
				default: begin
					state_q <= ASCP_IDLE;
				end
			endcase
		end
	end
	// configuration shifted in msb first on rising edges
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cfg_q <= '0;
		end else if (!cs_n && state_q == ASCP_CFG && rise) begin
			cfg_q <= {cfg_q[CFG_BITS-2:0], sdi}; // [R4] [R14]
		end
	end
	// hold the sample as acquisition closes, then shift out on falling edges
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			res_q <= '0;
			o_sdo <= 1'b0;
		end else if (cs_n) begin
			o_sdo <= 1'b0;
		end else if (state_q == ASCP_SAMPLE && (rise | fall) &&
			half_q == 2'(`ASCP_SAMPLE_HALF_EDGES - 1)) begin
			res_q <= quantise(i_analog_diff);
		end else if (state_q == ASCP_CONV && fall && bit_cnt_q != 5'(RES_BITS)) begin
			o_sdo <= res_q[RES_BITS-1]; // [R5] [R12]
			res_q <= {res_q[RES_BITS-2:0], 1'b0};
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_sdo_oe <= 1'b0;
			o_standby <= 1'b1;
			o_sampling <= 1'b0;
			o_cfg <= '0;
		end else begin
			o_sdo_oe <= !cs_n && state_q == ASCP_CONV && (fall || o_sdo_oe); // [R5]
			o_standby <= cs_n; // [R2]
			o_sampling <= !cs_n && state_q == ASCP_SAMPLE;
			o_cfg <= cfg_q;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	abort_idle_a: assert property (cs_n |=> state_q == ASCP_IDLE) // [R2]
		else $error("select high did not abort");
	standby_out_a: assert property (cs_n |=> o_standby) // [R2]
		else $error("standby not shown");
	standby_low_a: assert property (!cs_n |=> !o_standby) // [R1]
		else $error("standby shown while selected");
	sdo_quiet_a: assert property (cs_n |=> !o_sdo && !o_sdo_oe) // [R2]
		else $error("output still driven after abort");
	start_cfg_a: assert property (!cs_n && state_q == ASCP_IDLE |=> state_q == ASCP_CFG) // [R1]
		else $error("transaction did not start");
	sdo_fall_a: assert property (!cs_n && !fall && state_q != ASCP_IDLE |=> $stable(o_sdo)) // [R5]
		else $error("output moved off a falling edge");
	cfg_rise_a: assert property (!rise |=> $stable(cfg_q)) // [R4]
		else $error("configuration moved without rising edge");
	sample_len_a: assert property (state_q == ASCP_SAMPLE && !(rise | fall) && !cs_n
		|=> state_q == ASCP_SAMPLE) // [R7]
		else $error("sampling ended without a clock edge");
	conv_cap_a: assert property (bit_cnt_q <= 5'(RES_BITS)) // [R8]
		else $error("more than thirteen bits");
	no_clk_a: assert property (!(rise | fall) && !cs_n |=> $stable(bit_cnt_q) && $stable(half_q)) // [R6]
		else $error("progress without host clock");
	sat_a: assert property (state_q == ASCP_SAMPLE && (rise | fall) && half_q == 2'h2 && !cs_n
		&& i_analog_diff > $signed(15'sd4095) |=> res_q == `ASCP_CODE_MAX) // [R10]
		else $error("positive overrange not saturated");
	sat_neg_a: assert property (state_q == ASCP_SAMPLE && (rise | fall) && half_q == 2'h2 && !cs_n
		&& i_analog_diff < -15'sd4096 |=> res_q == `ASCP_CODE_MIN) // [R10]
		else $error("negative overrange not saturated");
	////////////////////////////////////////////////////////////////////////
	// acquisition flag and configuration length
	sampling_flag_a: assert property (!cs_n && state_q == ASCP_SAMPLE |=> o_sampling) // [R7]
		else $error("sampling flag missing");
	cfg_count_a: assert property (cfg_cnt_q <= ($clog2(CFG_BITS+1))'(CFG_BITS)) // [R14]
		else $error("too many configuration bits");
	////////////////////////////////////////////////////////////////////////
	// shifting of the result
	// the first falling edge in conversion puts out the held sign bit
	sign_first_a: assert property (state_q == ASCP_CONV && fall && bit_cnt_q == 5'h00 && !cs_n
		|=> o_sdo == $past(res_q[RES_BITS-1])) // [R12]
		else $error("sign bit not sent first");
	// once enabled the output stays driven until select rises
	oe_hold_a: assert property (o_sdo_oe && !cs_n |=> o_sdo_oe) // [R5]
		else $error("output enable dropped while selected");
	////////////////////////////////////////////////////////////////////////
	// main scenarios
	cv_sat_c: cover property (state_q == ASCP_SAMPLE && (rise | fall) && half_q == 2'h2
		&& i_analog_diff > $signed(15'sd4095));
	cv_cfg_c: cover property (state_q == ASCP_CFG ##1 state_q == ASCP_SAMPLE);
	cv_conv_c: cover property (state_q == ASCP_CONV && bit_cnt_q == 5'(RES_BITS));
	cv_abort_c: cover property (state_q == ASCP_CONV && cs_n);
	cv_sample_c: cover property (state_q == ASCP_SAMPLE ##1 state_q == ASCP_CONV);
endmodule : ascp_port
`default_nettype wire

// File: sim/ascp_host_model.sv
// serial host model facing the conversion port
`timescale 1ns/10ps
`default_nettype none
module ascp_host_model #(
	parameter int CFG_BITS = 5,
	parameter int HALF = 10
) (
	// clock and result pin
	input wire logic i_core_clk,
	input wire logic i_sdo,
	// host pins
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_sdi
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_sdi = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask : hw
	task automatic tick();
		hw(HALF);
		o_sclk = 1'b1;
		hw(HALF);
		o_sclk = 1'b0;
	endtask : tick
	// select, shift configuration, sample, read n_bits result bits
	task automatic xfer(input logic [CFG_BITS-1:0] cfg, input int n_bits, output logic [12:0] res);
		res = 13'h0000;
		o_cs_n = 1'b0;
		hw(HALF);
		for (int i = CFG_BITS - 1; i >= 0; i--) begin
			o_sdi = cfg[i];
			tick();
		end
		// released data line shows the inverse of its last level
		o_sdi = ~o_sdi;
		tick();
		for (int k = 0; k < n_bits; k++) begin
			tick();
			hw(8);
			res = {res[11:0], i_sdo};
		end
	endtask : xfer
	task automatic finish();
		hw(HALF);
		o_cs_n = 1'b1;
		hw(3 * HALF);
	endtask : finish
endmodule : ascp_host_model
`default_nettype wire

// File: sim/tb_adc_serial_conversion_port.sv
// self-checking bench of the serial conversion port
`timescale 1ns/10ps
`default_nettype none
module tb_adc_serial_conversion_port;
	import ascp_pkg::*;
	typedef struct packed {logic [14:0] ana; logic [4:0] cfg; logic [12:0] code;} ascp_row_t;
	logic i_core_clk, i_rst, cs_n, sclk, sdi, o_sdo, o_sdo_oe, o_standby, o_sampling;
	logic signed [14:0] i_analog_diff;
	logic [4:0] o_cfg;
	logic [12:0] res;
	int errors, n_compared, cycles;
	ascp_row_t rows [7] = '{'{15'h0000, 5'h1F, 13'h0000}, '{15'h0001, 5'h00, 13'h0001},
		'{15'h7FFF, 5'h15, 13'h1FFF}, '{15'h0FFF, 5'h0A, 13'h0FFF}, '{15'h7000, 5'h10, 13'h1000},
		'{15'h1388, 5'h01, 13'h0FFF}, '{15'h6890, 5'h1E, 13'h1000}};
	ascp_port uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_select_shutdown_n(cs_n), .i_sclk(sclk),
		.i_sdi(sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .i_analog_diff(i_analog_diff), .o_cfg(o_cfg),
		.o_standby(o_standby), .o_sampling(o_sampling));
	ascp_host_model host (.i_core_clk(i_core_clk), .i_sdo(o_sdo), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi));
	task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		i_rst = 1'b1;
		i_analog_diff = 15'h0000;
		repeat (2) @(negedge i_core_clk);
		i_rst = 1'b0;
		repeat (6) @(negedge i_core_clk);
		check("reset standby", 13'(o_standby), 13'h0001);
		check("reset oe", 13'(o_sdo_oe), 13'h0000);
		check("reset cfg", 13'(o_cfg), 13'h0000);
		check("reset sampling", 13'(o_sampling), 13'h0000);
		foreach (rows[r]) begin
			i_analog_diff = rows[r].ana;
			host.xfer(rows[r].cfg, 13, res);
			check("result", res, rows[r].code);
			check("cfg", 13'(o_cfg), 13'(rows[r].cfg));
			check("busy oe", 13'(o_sdo_oe), 13'h0001);
			check("busy standby", 13'(o_standby), 13'h0000);
			host.finish();
			check("idle standby", 13'(o_standby), 13'h0001);
		end
		// abort after four result bits, then convert again at once
		i_analog_diff = 15'h0AAA;
		host.xfer(5'h03, 4, res);
		check("partial", res, 13'h0005);
		host.finish();
		check("abort oe", 13'(o_sdo_oe), 13'h0000);
		check("abort sdo", 13'(o_sdo), 13'h0000);
		check("abort standby", 13'(o_standby), 13'h0001);
		i_analog_diff = 15'h7FF0;
		host.xfer(5'h0C, 13, res);
		check("restart", res, 13'h1FF0);
		host.finish();
		wrap_up();
	end
endmodule : tb_adc_serial_conversion_port
`default_nettype wire
